// >>> hw/scp_top.v
// system control ports: control, auxiliary, nmi mask, coprocessor strobes, post code
// assumes a single-cycle host i/o strobe and status inputs from other board clocks
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.vh"
module scp_top (
  input wire clk_sys_in,
  input wire reset_n_in,
  input wire [15:0] io_addr_in,
  input wire [7:0] io_wdata_in,
  input wire io_wr_in,
  input wire io_rd_in,
  input wire mem_perr_in,
  input wire bus_perr_in,
  input wire spk_tone_in,
  input wire refresh_in,
  output reg [7:0] io_rdata_out,
  output reg io_hit_out,
  output reg bus_perr_en_out,
  output reg mem_perr_en_out,
  output reg spk_data_out,
  output reg spk_gate_out,
  output reg [7:0] aux_ctrl_out,
  output reg nmi_mask_out,
  output reg fpu_busy_clr_out,
  output reg fpu_reset_out,
  output reg [7:0] post_code_out
);
  // reset images of the writable fields; bit positions follow the port layout
  localparam [3:0] CTRL_RST = `SCP_CTRL_RESET;
  localparam [7:0] AUX_RST = `SCP_AUX_RESET;
  localparam [0:0] NMI_RST = `SCP_NMI_RESET;
  localparam [7:0] POST_RST = `SCP_POST_RESET;
  localparam [7:0] RD_IDLE = `SCP_RDATA_IDLE; // shown whenever no mapped read is answered
  // positions of the four status levels in the synchroniser vector
  localparam ST_REFRESH = 0;
  localparam ST_SPK_TONE = 1;
  localparam ST_BUS_PERR = 2;
  localparam ST_MEM_PERR = 3;

  // status levels as they arrive from other board clocks
  wire [3:0] stat_raw;
  wire [3:0] stat_live;
  assign stat_raw = {mem_perr_in, bus_perr_in, spk_tone_in, refresh_in};

  // four flip-flops per level; a change is taken only once stages two and three
  // agree, so a one-cycle glitch never reaches the host, at the cost of dropping
  // pulses shorter than two cycles and about four cycles of latency
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      reg sync1_r;
      reg sync2_r;
      reg sync3_r;
      reg stat_r;
      always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
          sync1_r <= 1'b0;
          sync2_r <= 1'b0;
          sync3_r <= 1'b0;
          stat_r <= 1'b0;
        end else begin
          sync1_r <= stat_raw[g];
          sync2_r <= sync1_r;
          sync3_r <= sync2_r;
          if (sync2_r == sync3_r) begin
            stat_r <= sync3_r;
          end
        end
      end
      // only the filtered stage leaves the synchroniser
      assign stat_live[g] = stat_r;
    end
  endgenerate

  // full sixteen-bit compare; a partial decode would alias onto other peripherals
  function hit;
    input [15:0] a;
    input [15:0] ref_a;
    begin
      hit = (a == ref_a);
    end
  endfunction

  // one select per port, shared by the write, read and strobe paths
  wire sel_ctrl;
  wire sel_aux;
  wire sel_nmi;
  wire sel_post;
  wire sel_fpu_clr;
  wire sel_fpu_rst;
  wire io_acc;
  assign sel_ctrl = hit(io_addr_in, `SCP_ADDR_CTRL);
  assign sel_aux = hit(io_addr_in, `SCP_ADDR_AUX);
  assign sel_nmi = hit(io_addr_in, `SCP_ADDR_NMI);
  assign sel_post = hit(io_addr_in, `SCP_ADDR_POST);
  assign sel_fpu_clr = hit(io_addr_in, `SCP_ADDR_FPU_CLR);
  assign sel_fpu_rst = hit(io_addr_in, `SCP_ADDR_FPU_RST);
  assign io_acc = io_wr_in | io_rd_in;

  // next values of the host-writable fields
  reg bus_perr_en_nxt;
  reg mem_perr_en_nxt;
  reg spk_data_nxt;
  reg spk_gate_nxt;
  reg [7:0] aux_ctrl_nxt;
  reg nmi_mask_nxt;
  reg [7:0] post_code_nxt;

  // every field holds unless its own port is written; unmapped writes change nothing
  always @* begin
    bus_perr_en_nxt = bus_perr_en_out;
    mem_perr_en_nxt = mem_perr_en_out;
    spk_data_nxt = spk_data_out;
    spk_gate_nxt = spk_gate_out;
    aux_ctrl_nxt = aux_ctrl_out;
    nmi_mask_nxt = nmi_mask_out;
    post_code_nxt = post_code_out;
    if (io_wr_in) begin
      if (sel_ctrl) begin
        // bits 7..4 of the byte are status with no storage, so they are dropped here
        bus_perr_en_nxt = io_wdata_in[`SCP_CTRL_BUS_PEN];
        mem_perr_en_nxt = io_wdata_in[`SCP_CTRL_MEM_PEN];
        spk_data_nxt = io_wdata_in[`SCP_CTRL_SPK_DATA];
        spk_gate_nxt = io_wdata_in[`SCP_CTRL_SPK_GATE];
      end
      if (sel_aux) begin
        // stored raw: bits 7,5,4,3,1 are active-low enables and 6,2,0 active high;
        // consumers decode the polarity, so a readback shows exactly what was written
        aux_ctrl_nxt = io_wdata_in;
      end
      if (sel_nmi) begin
        // the low seven bits are the clock's index and are decoded by the clock itself
        nmi_mask_nxt = io_wdata_in[`SCP_NMI_MASK_BIT];
      end
      if (sel_post) begin
        // the last code stays visible for an external debug probe
        post_code_nxt = io_wdata_in;
      end
    end
  end

  // writable fields; each drives its output straight from the flip-flop
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      bus_perr_en_out <= CTRL_RST[`SCP_CTRL_BUS_PEN];
      mem_perr_en_out <= CTRL_RST[`SCP_CTRL_MEM_PEN];
      spk_data_out <= CTRL_RST[`SCP_CTRL_SPK_DATA];
      spk_gate_out <= CTRL_RST[`SCP_CTRL_SPK_GATE];
      aux_ctrl_out <= AUX_RST;
      nmi_mask_out <= NMI_RST;
      post_code_out <= POST_RST;
    end else begin
      bus_perr_en_out <= bus_perr_en_nxt;
      mem_perr_en_out <= mem_perr_en_nxt;
      spk_data_out <= spk_data_nxt;
      spk_gate_out <= spk_gate_nxt;
      aux_ctrl_out <= aux_ctrl_nxt;
      nmi_mask_out <= nmi_mask_nxt;
      post_code_out <= post_code_nxt;
    end
  end

  // coprocessor strobes fire on a read or a write alike, for one cycle
  reg fpu_busy_clr_nxt;
  reg fpu_reset_nxt;
  always @* begin
    fpu_busy_clr_nxt = io_acc & sel_fpu_clr;
    fpu_reset_nxt = io_acc & sel_fpu_rst;
  end

  // registered so the coprocessor sees a clean pulse one cycle after the access
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      fpu_busy_clr_out <= 1'b0;
      fpu_reset_out <= 1'b0;
    end else begin
      fpu_busy_clr_out <= fpu_busy_clr_nxt;
      fpu_reset_out <= fpu_reset_nxt;
    end
  end

  // read mux: the nmi port reads as unmapped, since the real-time clock answers there
  reg [7:0] rdata_nxt;
  reg hit_nxt;
  always @* begin
    rdata_nxt = RD_IDLE;
    hit_nxt = 1'b0;
    if (io_rd_in) begin
      if (sel_ctrl) begin
        // status half is live hardware state, never the bits last written
        rdata_nxt[`SCP_CTRL_MEM_PERR] = stat_live[ST_MEM_PERR];
        rdata_nxt[`SCP_CTRL_BUS_PERR] = stat_live[ST_BUS_PERR];
        rdata_nxt[`SCP_CTRL_SPK_TONE] = stat_live[ST_SPK_TONE];
        rdata_nxt[`SCP_CTRL_REFRESH] = stat_live[ST_REFRESH];
        rdata_nxt[`SCP_CTRL_BUS_PEN] = bus_perr_en_out;
        rdata_nxt[`SCP_CTRL_MEM_PEN] = mem_perr_en_out;
        rdata_nxt[`SCP_CTRL_SPK_DATA] = spk_data_out;
        rdata_nxt[`SCP_CTRL_SPK_GATE] = spk_gate_out;
        hit_nxt = 1'b1;
      end else if (sel_aux) begin
        rdata_nxt = aux_ctrl_out;
        hit_nxt = 1'b1;
      end else if (sel_post) begin
        rdata_nxt = post_code_out;
        hit_nxt = 1'b1;
      end
    end
  end

  // read answer stands for exactly one cycle, then returns to the idle value
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      io_rdata_out <= RD_IDLE;
      io_hit_out <= 1'b0;
    end else begin
      io_rdata_out <= rdata_nxt;
      io_hit_out <= hit_nxt;
    end
  end
endmodule // scp_top
`default_nettype wire

// >>> hw/scp_defines.vh
// constants for the system control ports block
// assumes an 8-bit host i/o bus with a 16-bit address
`ifndef SCP_DEFINES_VH
`define SCP_DEFINES_VH
`define SCP_ADDR_CTRL 16'h0061
`define SCP_ADDR_NMI 16'h0070
`define SCP_ADDR_AUX 16'h0078
`define SCP_ADDR_POST 16'h0080
`define SCP_ADDR_FPU_CLR 16'h00f0
`define SCP_ADDR_FPU_RST 16'h00f1
`define SCP_CTRL_MEM_PERR 7
`define SCP_CTRL_BUS_PERR 6
`define SCP_CTRL_SPK_TONE 5
`define SCP_CTRL_REFRESH 4
`define SCP_CTRL_BUS_PEN 3
`define SCP_CTRL_MEM_PEN 2
`define SCP_CTRL_SPK_DATA 1
`define SCP_CTRL_SPK_GATE 0
`define SCP_AUX_SPK_DIS 7
`define SCP_AUX_VSHADOW 6
`define SCP_AUX_FDC_DIS 5
`define SCP_AUX_HDC_DIS 4
`define SCP_AUX_VID_DIS 3
`define SCP_AUX_MONO 2
`define SCP_AUX_HALG_DIS 1
`define SCP_AUX_SLOW 0
`define SCP_NMI_MASK_BIT 7
`define SCP_CTRL_RESET 4'h0
`define SCP_AUX_RESET 8'h00
`define SCP_NMI_RESET 1'b1
`define SCP_POST_RESET 8'h00
`define SCP_RDATA_IDLE 8'h00
`endif

// >>> bench/scp_assertions.sv
// checker: port-level properties of the control ports block
// assumes it is bound onto scp_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module scp_chk (
  input wire clk_sys_in, reset_n_in, io_wr_in, io_rd_in, io_hit_out, nmi_mask_out,
  input wire fpu_busy_clr_out, fpu_reset_out, bus_perr_en_out, mem_perr_en_out,
  input wire spk_data_out, spk_gate_out,
  input wire [15:0] io_addr_in,
  input wire [7:0] io_wdata_in, aux_ctrl_out, post_code_out, io_rdata_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // short aliases keep each property on a readable line
  wire [15:0] a = io_addr_in;
  wire acc = io_wr_in | io_rd_in;
  AST_AUX: assert property (io_wr_in && a == 16'h0078 |=> aux_ctrl_out == $past(io_wdata_in))
    else $error("aux write lost");
  AST_AUX_KEEP: assert property (!(io_wr_in && a == 16'h0078) |=> $stable(aux_ctrl_out))
    else $error("aux changed");
  AST_POST: assert property (io_wr_in && a == 16'h0080 |=> post_code_out == $past(io_wdata_in))
    else $error("post code lost");
  AST_NMI: assert property (io_wr_in && a == 16'h0070 |=> nmi_mask_out == $past(io_wdata_in[7]))
    else $error("nmi mask wrong");
  AST_EN: assert property (io_wr_in && a == 16'h0061 |=>
    {bus_perr_en_out, mem_perr_en_out, spk_data_out, spk_gate_out} == $past(io_wdata_in[3:0]))
    else $error("control bits wrong");
  AST_CLR: assert property (acc && a == 16'h00f0 |=> fpu_busy_clr_out)
    else $error("busy clear missing");
  AST_RST: assert property (!(acc && a == 16'h00f1) |=> !fpu_reset_out)
    else $error("spurious reset");
  AST_HIT: assert property (!io_rd_in |=> !io_hit_out)
    else $error("hit without read");
  AST_CLR_OFF: assert property (!(acc && a == 16'h00f0) |=> !fpu_busy_clr_out)
    else $error("spurious busy clear");
  AST_RST_ON: assert property (acc && a == 16'h00f1 |=> fpu_reset_out)
    else $error("coprocessor reset missing");
  AST_RD_CTRL: assert property (io_rd_in && a == 16'h0061 |=> io_hit_out &&
    io_rdata_out[3:0] == $past({bus_perr_en_out, mem_perr_en_out, spk_data_out, spk_gate_out}))
    else $error("control readback wrong");
  AST_RD_NMI: assert property (io_rd_in && a == 16'h0070 |=> !io_hit_out && io_rdata_out == 8'h00)
    else $error("nmi port answered a read");
  AST_RD_POST: assert property (io_rd_in && a == 16'h0080 |=> io_rdata_out == $past(post_code_out))
    else $error("post readback wrong");
  cover property (io_hit_out);
  cover property (fpu_reset_out);
  cover property (!nmi_mask_out);
  cover property (fpu_busy_clr_out);
endmodule // scp_chk
bind scp_top scp_chk chk_u (.*);
`default_nettype wire

// >>> bench/scp_host.sv
// host model: single-cycle i/o writes and reads
// assumes the block samples strobes on the rising edge
`timescale 1ns/1ps
`default_nettype none
module scp_host (
  input wire clk_sys_in, io_hit_out,
  input wire [7:0] io_rdata_out,
  output logic [15:0] io_addr_in,
  output logic [7:0] io_wdata_in,
  output logic io_wr_in, io_rd_in
);
  initial {io_addr_in, io_wdata_in, io_wr_in, io_rd_in} = 26'h0;
  // after the strobe the lines flip so stale values cannot pass
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
    output logic [8:0] q);
    @(negedge clk_sys_in);
    {io_addr_in, io_wdata_in, io_wr_in, io_rd_in} = {a, d, w, !w};
    @(negedge clk_sys_in);
    q = {io_hit_out, io_rdata_out};
    {io_addr_in, io_wdata_in, io_wr_in, io_rd_in} = {~a, ~d, 2'b00};
  endtask
endmodule // scp_host
`default_nettype wire

// >>> bench/tb_top.sv
// testbench: host accesses to every port with expected values
// assumes scp_top and scp_host share these signal names
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys_in, reset_n_in, mem_perr_in, bus_perr_in, spk_tone_in, refresh_in, io_wr_in;
  logic io_rd_in, io_hit_out, bus_perr_en_out, mem_perr_en_out, spk_data_out, spk_gate_out;
  logic nmi_mask_out, fpu_busy_clr_out, fpu_reset_out;
  logic [15:0] io_addr_in;
  logic [7:0] io_wdata_in, io_rdata_out, aux_ctrl_out, post_code_out;
  logic [8:0] q;
  int err_total = 0;
  int samples_checked = 0;
  scp_top dut_u (.*);
  scp_host host_u (.*);
  // case inequality so an unknown never matches
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one access, then its {hit, data} answer
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [8:0] e);
    host_u.acc(w, a, d, q);
    chk(q, e);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // 200 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // the run needs about 46 cycles, so 2 us means a hang
  initial begin
    #2000;
    err_total++;
    summarize;
  end
  // status held at memory parity error plus refresh
  initial begin
    {reset_n_in, mem_perr_in, bus_perr_in, spk_tone_in, refresh_in} = 5'h09;
    repeat (12) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    chk({nmi_mask_out, aux_ctrl_out}, 9'h100);
    io(1'b1, 16'h0078, 8'ha5, 9'h000);
    io(1'b0, 16'h0078, 8'h00, 9'h1a5);
    io(1'b1, 16'h0061, 8'h6e, 9'h000);
    chk({5'h00, bus_perr_en_out, mem_perr_en_out, spk_data_out, spk_gate_out}, 9'h00e);
    io(1'b0, 16'h0061, 8'h00, 9'h19e);
    io(1'b1, 16'h0070, 8'h7f, 9'h000);
    chk({8'h00, nmi_mask_out}, 9'h000);
    io(1'b1, 16'h0080, 8'h2b, 9'h000);
    chk({1'b0, post_code_out}, 9'h02b);
    io(1'b0, 16'h0080, 8'h00, 9'h12b);
    io(1'b1, 16'h00f0, 8'h00, 9'h000);
    chk({7'h00, fpu_busy_clr_out, fpu_reset_out}, 9'h002);
    io(1'b0, 16'h00f1, 8'h00, 9'h000);
    chk({7'h00, fpu_busy_clr_out, fpu_reset_out}, 9'h001);
    // second status pattern: bus parity error and speaker tone high, so bits 6,5 rise and bits 7,4 fall
    {mem_perr_in, bus_perr_in, spk_tone_in, refresh_in} = 4'h6;
    repeat (4) @(negedge clk_sys_in);
    io(1'b0, 16'h0061, 8'h00, 9'h16e);
    io(1'b0, 16'h0070, 8'h00, 9'h000);
    // reset in mid-run: written fields return to reset values, status re-syncs
    reset_n_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    chk({nmi_mask_out, aux_ctrl_out}, 9'h100);
    chk({1'b0, post_code_out}, 9'h000);
    repeat (4) @(negedge clk_sys_in);
    io(1'b0, 16'h0061, 8'h00, 9'h160);
    summarize;
  end
endmodule // tb_top
`default_nettype wire
